// >>> design/exec_defs.svh
// Function
// RL1 - add registers, optional carry, full flags
// RL2 - subtract registers, optional borrow, full flags
// RL3 - subtract immediate, optional borrow, full flags
// RL4 - and/or/xor update zero, negative, overflow only; the code also updates sign
// RL5 - set bits or, clear bits and-not mask
// RL6 - test ands register with itself
// RL7 - invert and sign flip with their flags
// RL8 - increment, decrement, clear, all-ones load
// RL9 - relative jump two, call three cycles
// RL10 - returns restore pc in four cycles
// RL11 - equal skip, one or two cycles
// RL12 - compares set flags, store nothing
// RL13 - register bit skips, one or two cycles
// RL14 - io bit skips, one or two cycles
// RL15 - generic flag branch, pc plus offset plus one
// RL16 - branches one cycle, two when taken
// RL17 - unsigned, equal, sign branches on carry/zero/negative
// RL18 - signed compare branches on negative xor overflow
// RL19 - half-carry branches on set or clear
// RL20 - transfer flag branches on set or clear
// RL21 - overflow branches on set or clear
// RL22 - interrupt enable branches on set or clear
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// ****************************************
// flag positions in cpu_flags_register
// ****************************************
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
`define FLAG_MSB 7
`define HALF_MSB 3

// ****************************************
// byte constants and reset values
// ****************************************
`define ALL_ONES 8'hFF
`define ZERO_BYTE 8'h00
`define ONE_BYTE 8'h01
`define MOST_NEG 8'h80
`define MOST_POS 8'h7F
`define FLAGS_RESET 8'h00
`define RESULT_RESET 8'h00
`define PC_RESET_BIT 1'b0

// ****************************************
// cycle counts and pc steps
// ****************************************
`define CYC_NONE 3'h0
`define CYC_ONE 3'h1
`define CYC_JUMP 3'h2
`define CYC_CALL 3'h3
`define CYC_RETURN 3'h4
`define CYC_SKIP 3'h2
`define CYC_TAKEN 3'h2
`define PC_STEP 1
`define SKIP_SHORT 2
`define SKIP_LONG 3

`endif

// >>> design/exec_pkg.sv
package exec_pkg;
  typedef enum logic [5:0] {
    no_operation, add_regs, add_with_carry, minus_regs, minus_immediate, minus_with_borrow,
    minus_imm_with_borrow, and_regs, mask_with_immediate, or_regs, merge_immediate_bits,
    exclusive_or_regs, bitwise_invert, sign_flip, set_mask_bits, clear_mask_bits, plus_one,
    minus_one, zero_or_sign_check, zero_register, all_ones_load, relative_jump,
    relative_subroutine_call, subroutine_exit, interrupt_exit, equal_skip, compare_regs,
    compare_with_borrow, compare_immediate, skip_if_reg_bit_clear, skip_if_reg_bit_set,
    skip_if_io_bit_clear, skip_if_io_bit_set, branch_on_flag_set, branch_on_flag_clear,
    branch_signed_ge, branch_signed_lt, branch_unsigned_ge, branch_unsigned_lt
  } exec_op_t;
  typedef logic [7:0] byte_t;
endpackage

// >>> design/exec_if.sv
`timescale 1ns/1ps
interface exec_if;
  import exec_pkg::*;
  exec_op_t op;
  byte_t dst;
  byte_t src;
  byte_t imm;
  byte_t io_data;
  logic [2:0] bit_sel;
  byte_t flags_in;
  byte_t result;
  byte_t flags_out;
  logic write_dst;
  logic cond_take;
  modport main (output op, dst, src, imm, io_data, bit_sel, flags_in,
                input result, flags_out, write_dst, cond_take);
  modport alu (input op, dst, src, imm, flags_in, output result, flags_out, write_dst);
  modport cond (input op, dst, src, io_data, bit_sel, flags_in, output cond_take);
endinterface

// >>> design/exec_alu.sv
`timescale 1ns/1ps
`include "exec_defs.svh"
module exec_alu
  import exec_pkg::*;
(
  exec_if.alu ifc
);
  // ****************************************
  // operand selection
  // ****************************************
  wire use_imm = ifc.op inside {minus_immediate, minus_imm_with_borrow, mask_with_immediate,
                                merge_immediate_bits, set_mask_bits, clear_mask_bits, compare_immediate};
  wire with_borrow = ifc.op inside {minus_with_borrow, minus_imm_with_borrow, compare_with_borrow};
  wire is_flip = (ifc.op == sign_flip);
  wire [7:0] opnd_b = use_imm ? ifc.imm : ifc.src;
  wire carry_in = (ifc.op == add_with_carry) & ifc.flags_in[`FLAG_C];
  wire borrow_in = with_borrow & ifc.flags_in[`FLAG_C];
  wire [7:0] sub_a = is_flip ? `ZERO_BYTE : ifc.dst;
  wire [7:0] sub_b = is_flip ? ifc.dst : opnd_b;
  wire [8:0] sum9 = {1'b0, ifc.dst} + {1'b0, opnd_b} + {8'h00, carry_in};
  wire [8:0] diff9 = {1'b0, sub_a} - {1'b0, sub_b} - {8'h00, borrow_in};

  // ****************************************
  // carry, half-carry and overflow terms
  // ****************************************
  wire a3 = ifc.dst[`HALF_MSB];
  wire b3 = opnd_b[`HALF_MSB];
  wire s3 = sum9[`HALF_MSB];
  wire a7 = ifc.dst[`FLAG_MSB];
  wire b7 = opnd_b[`FLAG_MSB];
  wire s7 = sum9[`FLAG_MSB];
  wire h_add = (a3 & b3) | (b3 & ~s3) | (~s3 & a3);
  wire v_add = (a7 & b7 & ~s7) | (~a7 & ~b7 & s7);
  wire x3 = sub_a[`HALF_MSB];
  wire y3 = sub_b[`HALF_MSB];
  wire d3 = diff9[`HALF_MSB];
  wire x7 = sub_a[`FLAG_MSB];
  wire y7 = sub_b[`FLAG_MSB];
  wire d7 = diff9[`FLAG_MSB];
  wire h_sub = (~x3 & y3) | (y3 & d3) | (d3 & ~x3);
  wire v_sub = (x7 & ~y7 & ~d7) | (~x7 & y7 & d7);

  // ****************************************
  // result and flag update
  // ****************************************
  always_comb begin
    logic upd_zn;
    upd_zn = 1'b1;
    ifc.result = ifc.dst;
    ifc.flags_out = ifc.flags_in;
    ifc.write_dst = 1'b1;
    case (ifc.op)
      add_regs, add_with_carry: begin
        ifc.result = sum9[7:0]; // RL1
        ifc.flags_out[`FLAG_C] = sum9[8];
        ifc.flags_out[`FLAG_H] = h_add;
        ifc.flags_out[`FLAG_V] = v_add;
      end
      minus_regs, minus_with_borrow, minus_immediate, minus_imm_with_borrow, sign_flip,
      compare_regs, compare_with_borrow, compare_immediate: begin
        ifc.result = diff9[7:0]; // RL2 RL3 RL7
        ifc.flags_out[`FLAG_C] = diff9[8];
        ifc.flags_out[`FLAG_H] = h_sub;
        ifc.flags_out[`FLAG_V] = v_sub;
        ifc.write_dst = !(ifc.op inside {compare_regs, compare_with_borrow, compare_immediate}); // RL12
      end
      and_regs, mask_with_immediate: begin
        ifc.result = ifc.dst & opnd_b; // RL4
        ifc.flags_out[`FLAG_V] = 1'b0;
      end
      or_regs, merge_immediate_bits, set_mask_bits: begin
        ifc.result = ifc.dst | opnd_b; // RL4 RL5
        ifc.flags_out[`FLAG_V] = 1'b0;
      end
      exclusive_or_regs: begin
        ifc.result = ifc.dst ^ opnd_b; // RL4
        ifc.flags_out[`FLAG_V] = 1'b0;
      end
      clear_mask_bits: begin
        ifc.result = ifc.dst & (`ALL_ONES - ifc.imm); // RL5
        ifc.flags_out[`FLAG_V] = 1'b0;
      end
      zero_or_sign_check: begin
        ifc.result = ifc.dst & ifc.dst; // RL6
        ifc.flags_out[`FLAG_V] = 1'b0;
      end
      zero_register: begin
        ifc.result = ifc.dst ^ ifc.dst; // RL8
        ifc.flags_out[`FLAG_V] = 1'b0;
      end
      bitwise_invert: begin
        ifc.result = `ALL_ONES - ifc.dst; // RL7
        ifc.flags_out[`FLAG_C] = 1'b1;
        ifc.flags_out[`FLAG_V] = 1'b0;
      end
      plus_one: begin
        ifc.result = ifc.dst + `ONE_BYTE; // RL8
        ifc.flags_out[`FLAG_V] = (ifc.dst == `MOST_POS);
      end
      minus_one: begin
        ifc.result = ifc.dst - `ONE_BYTE; // RL8
        ifc.flags_out[`FLAG_V] = (ifc.dst == `MOST_NEG);
      end
      all_ones_load: begin
        ifc.result = `ALL_ONES; // RL8
        upd_zn = 1'b0;
      end
      default: begin
        ifc.write_dst = 1'b0;
        upd_zn = 1'b0;
      end
    endcase
    if (upd_zn) begin
      ifc.flags_out[`FLAG_N] = ifc.result[`FLAG_MSB];
      // borrow chains keep zero only while every byte was zero
      ifc.flags_out[`FLAG_Z] = (ifc.result == `ZERO_BYTE) & (!with_borrow | ifc.flags_in[`FLAG_Z]);
      ifc.flags_out[`FLAG_S] = ifc.flags_out[`FLAG_N] ^ ifc.flags_out[`FLAG_V];
    end
  end
endmodule

// >>> design/exec_cond.sv
`timescale 1ns/1ps
`include "exec_defs.svh"
module exec_cond
  import exec_pkg::*;
(
  exec_if.cond ifc
);
  function automatic logic bit_pick(input logic [7:0] v, input logic [2:0] i);
    return v[i];
  endfunction

  // ****************************************
  // tested bits
  // ****************************************
  wire reg_bit = bit_pick(ifc.src, ifc.bit_sel);
  wire io_bit = bit_pick(ifc.io_data, ifc.bit_sel);
  wire flag_bit = bit_pick(ifc.flags_in, ifc.bit_sel);
  wire n_xor_v = ifc.flags_in[`FLAG_N] ^ ifc.flags_in[`FLAG_V];

  always_comb begin
    case (ifc.op)
      equal_skip: ifc.cond_take = (ifc.dst == ifc.src); // RL11
      skip_if_reg_bit_clear: ifc.cond_take = !reg_bit; // RL13
      skip_if_reg_bit_set: ifc.cond_take = reg_bit; // RL13
      skip_if_io_bit_clear: ifc.cond_take = !io_bit; // RL14
      skip_if_io_bit_set: ifc.cond_take = io_bit; // RL14
      // any flag by index: carry, zero, negative, overflow, sign, half, transfer, interrupt
      branch_on_flag_set: ifc.cond_take = flag_bit; // RL15 RL17 RL19 RL20 RL21 RL22
      branch_on_flag_clear: ifc.cond_take = !flag_bit; // RL15 RL17 RL19 RL20 RL21 RL22
      branch_signed_ge: ifc.cond_take = !n_xor_v; // RL18
      branch_signed_lt: ifc.cond_take = n_xor_v; // RL18
      branch_unsigned_ge: ifc.cond_take = !ifc.flags_in[`FLAG_C]; // RL17
      branch_unsigned_lt: ifc.cond_take = ifc.flags_in[`FLAG_C]; // RL17
      default: ifc.cond_take = 1'b0;
    endcase
  end
endmodule

// >>> design/exec_unit.sv
`timescale 1ns/1ps
`include "exec_defs.svh"
module exec_unit
  import exec_pkg::*;
#(
  parameter int PC_W = 9,
  parameter int OFS_W = 12
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire exec_op_t op,
  input wire logic [7:0] dst_value,
  input wire logic [7:0] src_value,
  input wire logic [7:0] imm_value,
  input wire logic [2:0] bit_index,
  input wire logic [7:0] io_value,
  input wire logic [OFS_W-1:0] offset,
  input wire logic next_two_word,
  input wire logic [PC_W-1:0] stack_pc,
  output logic op_ready,
  output logic [7:0] result_value,
  output logic result_we,
  output logic [PC_W-1:0] pc,
  output logic [7:0] cpu_flags_register,
  output logic stack_push,
  output logic [PC_W-1:0] push_pc,
  output logic stack_pop
);
  if (PC_W < 2 || PC_W > 16 || OFS_W < 2 || OFS_W > 16) begin : bad_width
    $error("exec_unit: PC_W and OFS_W must lie in 2..16");
  end

  // ****************************************
  // datapath submodules
  // ****************************************
  exec_if ifc ();
  assign ifc.op = op;
  assign ifc.dst = dst_value;
  assign ifc.src = src_value;
  assign ifc.imm = imm_value;
  assign ifc.io_data = io_value;
  assign ifc.bit_sel = bit_index;
  assign ifc.flags_in = cpu_flags_register;

  exec_alu u_alu (.ifc(ifc));
  exec_cond u_cond (.ifc(ifc));

  // ****************************************
  // decode and next pc
  // ****************************************
  logic [2:0] remain;
  logic [2:0] next_cycles;
  logic [PC_W-1:0] next_pc;
  wire take = op_valid & op_ready;
  wire is_jump = (op == relative_jump);
  wire is_call = (op == relative_subroutine_call);
  wire is_ret = op inside {subroutine_exit, interrupt_exit};
  wire is_skip = op inside {equal_skip, skip_if_reg_bit_clear, skip_if_reg_bit_set,
                            skip_if_io_bit_clear, skip_if_io_bit_set};
  wire is_branch = op inside {branch_on_flag_set, branch_on_flag_clear, branch_signed_ge,
                              branch_signed_lt, branch_unsigned_ge, branch_unsigned_lt};
  wire [31:0] ofs_ext = 32'(signed'(offset));
  wire [PC_W-1:0] pc_inc = pc + PC_W'(`PC_STEP);
  wire [PC_W-1:0] pc_rel = pc + ofs_ext[PC_W-1:0] + PC_W'(`PC_STEP);
  wire [PC_W-1:0] skip_step = next_two_word ? PC_W'(`SKIP_LONG) : PC_W'(`SKIP_SHORT);
  wire [PC_W-1:0] pc_skip = pc + skip_step;
  wire rel_move = is_jump | is_call | (is_branch & ifc.cond_take);

  assign next_pc = is_ret ? stack_pc : // RL10
                   rel_move ? pc_rel : // RL9 RL15
                   (is_skip & ifc.cond_take) ? pc_skip : pc_inc; // RL11 RL13 RL14
  assign next_cycles = is_ret ? `CYC_RETURN : // RL10
                       is_call ? `CYC_CALL : // RL9
                       is_jump ? `CYC_JUMP : // RL9
                       (is_skip & ifc.cond_take) ? `CYC_SKIP : // RL11 RL13 RL14
                       (is_branch & ifc.cond_take) ? `CYC_TAKEN : `CYC_ONE; // RL16
  assign op_ready = (remain == `CYC_NONE);

  // ****************************************
  // architectural state
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      remain <= `CYC_NONE;
    end else if (take) begin
      remain <= next_cycles - `CYC_ONE;
    end else if (remain != `CYC_NONE) begin
      remain <= remain - `CYC_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc <= {PC_W{`PC_RESET_BIT}};
    end else if (take) begin
      pc <= next_pc;
    end
  end

  // skips, branches, jumps, calls and subroutine returns leave the flags alone; interrupt returns set I
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpu_flags_register <= `FLAGS_RESET;
    end else if (take) begin
      cpu_flags_register <= ifc.flags_out; // RL16
      if (op == interrupt_exit) begin
        cpu_flags_register[`FLAG_I] <= 1'b1; // RL10
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      result_value <= `RESULT_RESET;
      result_we <= 1'b0;
    end else begin
      result_we <= take & ifc.write_dst;
      if (take) begin
        result_value <= ifc.result;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      push_pc <= {PC_W{`PC_RESET_BIT}};
    end else begin
      stack_push <= take & is_call; // RL9
      stack_pop <= take & is_ret; // RL10
      if (take & is_call) begin
        push_pc <= pc_inc;
      end
    end
  end
endmodule

// >>> dv/exec_unit_checker.sv
`timescale 1ns/1ps
module exec_unit_checker
  import exec_pkg::*;
#(
  parameter int PC_W = 9,
  parameter int OFS_W = 12
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire exec_op_t op,
  input wire logic [7:0] dst_value,
  input wire logic [7:0] src_value,
  input wire logic [7:0] imm_value,
  input wire logic [2:0] bit_index,
  input wire logic [7:0] io_value,
  input wire logic [OFS_W-1:0] offset,
  input wire logic next_two_word,
  input wire logic [PC_W-1:0] stack_pc,
  input wire logic op_ready,
  input wire logic [7:0] result_value,
  input wire logic result_we,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0] cpu_flags_register,
  input wire logic stack_push,
  input wire logic [PC_W-1:0] push_pc,
  input wire logic stack_pop
);
  // ****************************************
  // accepted request and operation groups
  // ****************************************
  wire take = op_valid && op_ready;
  wire ret_op = op inside {subroutine_exit, interrupt_exit};
  wire skip_op = op inside {equal_skip, skip_if_reg_bit_clear, skip_if_reg_bit_set, skip_if_io_bit_clear,
                            skip_if_io_bit_set};
  wire br_op = op inside {branch_on_flag_set, branch_on_flag_clear, branch_signed_ge, branch_signed_lt,
                          branch_unsigned_ge, branch_unsigned_lt};
  wire logic_op = op inside {and_regs, mask_with_immediate, or_regs, merge_immediate_bits, exclusive_or_regs};
  wire cmp_op = op inside {compare_regs, compare_with_borrow, compare_immediate};
  wire keep_op = skip_op || br_op || op == relative_jump || op == relative_subroutine_call || op == subroutine_exit;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  property p_jump;
    take && op == relative_jump |=> !op_ready ##1 op_ready;
  endproperty
  a_jump: assert property (p_jump) else $error("jump length wrong");
  property p_call;
    take && op == relative_subroutine_call |=> stack_push && !op_ready && push_pc == $past(pc) + 1'b1
      ##1 !stack_push && !op_ready ##1 op_ready;
  endproperty
  a_call: assert property (p_call) else $error("call push or length wrong");
  property p_return;
    take && ret_op |=> stack_pop && !op_ready && pc == $past(stack_pc) ##1 !op_ready[*2] ##1 op_ready;
  endproperty
  a_return: assert property (p_return) else $error("return pc or length wrong");
  property p_int_flag;
    take && op == interrupt_exit |=> cpu_flags_register[7];
  endproperty
  a_int_flag: assert property (p_int_flag) else $error("interrupt enable not set");
  property p_flow_flags;
    take && keep_op |=> $stable(cpu_flags_register);
  endproperty
  a_flow_flags: assert property (p_flow_flags) else $error("flow op changed flags");
  property p_branch;
    take && br_op |=> (op_ready && pc == $past(pc) + 1'b1) or (!op_ready ##1 op_ready);
  endproperty
  a_branch: assert property (p_branch) else $error("branch timing wrong");
  property p_skip;
    take && skip_op |=> (op_ready && pc == $past(pc) + 1'b1)
      or (!op_ready && pc == $past(pc) + ($past(next_two_word) ? 2'h3 : 2'h2) ##1 op_ready);
  endproperty
  a_skip: assert property (p_skip) else $error("skip step wrong");
  property p_logic_keep;
    take && logic_op |=> (cpu_flags_register & 8'h21) == ($past(cpu_flags_register) & 8'h21) && result_we;
  endproperty
  a_logic_keep: assert property (p_logic_keep) else $error("logic op touched carry");
  property p_ones;
    take && op == all_ones_load |=> result_we && result_value == 8'hFF && $stable(cpu_flags_register);
  endproperty
  a_ones: assert property (p_ones) else $error("all ones load wrong");
  property p_add;
    take && op == add_regs |=> result_we && result_value == 8'($past(dst_value) + $past(src_value));
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");
  property p_cmp;
    take && cmp_op |=> !result_we && op_ready;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare stored result");
  property p_clear_bits;
    take && op == clear_mask_bits |=> result_value == ($past(dst_value) & ~$past(imm_value))
      && cpu_flags_register[1] == (result_value == 8'h00);
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear bits wrong");
endmodule

bind exec_unit exec_unit_checker #(.PC_W(PC_W), .OFS_W(OFS_W)) exec_unit_checker_inst (
  .core_clk(core_clk), .srst(srst), .op_valid(op_valid), .op(op), .dst_value(dst_value),
  .src_value(src_value), .imm_value(imm_value), .bit_index(bit_index), .io_value(io_value),
  .offset(offset), .next_two_word(next_two_word), .stack_pc(stack_pc), .op_ready(op_ready),
  .result_value(result_value), .result_we(result_we), .pc(pc), .cpu_flags_register(cpu_flags_register),
  .stack_push(stack_push), .push_pc(push_pc), .stack_pop(stack_pop));

// >>> dv/test_exec_unit.sv
`timescale 1ns/1ps
module test_exec_unit;
  import exec_pkg::*;
  localparam int PC_W = 9;
  localparam int OFS_W = 12;
  typedef struct {exec_op_t op; byte_t d, s, k, r, f; logic w;} alu_case_t;
  typedef struct {exec_op_t op; byte_t s; logic [2:0] b; logic [11:0] o; logic t; int dp, cy;} flow_case_t;
  logic core_clk = 1'b0, srst = 1'b1, op_valid = 1'b0, next_two_word = 1'b0;
  exec_op_t op = no_operation;
  byte_t dst_value = 8'h00, src_value = 8'h00, imm_value = 8'h00, io_value = 8'h00;
  logic [2:0] bit_index = 3'h0;
  logic [OFS_W-1:0] offset = 12'h000;
  logic [PC_W-1:0] stack_pc = 9'h000;
  logic op_ready, result_we, stack_push, stack_pop;
  logic [7:0] result_value, cpu_flags_register;
  logic [PC_W-1:0] pc, push_pc, exp_pc;
  int err_count = 0, tests_run = 0, cyc = 0, cycles = 0;

  exec_unit #(.PC_W(PC_W), .OFS_W(OFS_W)) exec_unit_inst (
    .core_clk(core_clk), .srst(srst), .op_valid(op_valid), .op(op), .dst_value(dst_value),
    .src_value(src_value), .imm_value(imm_value), .bit_index(bit_index), .io_value(io_value),
    .offset(offset), .next_two_word(next_two_word), .stack_pc(stack_pc), .op_ready(op_ready),
    .result_value(result_value), .result_we(result_we), .pc(pc), .cpu_flags_register(cpu_flags_register),
    .stack_push(stack_push), .push_pc(push_pc), .stack_pop(stack_pop));

  always #50 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      err_count = err_count + 1;
      complete_run();
    end
  end

  // ****************************************
  // compare and drive tasks
  // ****************************************
  task automatic chk_data(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pc(input string nm, input logic [PC_W-1:0] e, input logic [PC_W-1:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  // one request, then count busy cycles until ready again
  task automatic run_op(input exec_op_t o, input byte_t d, input byte_t s, input byte_t k, input logic [2:0] b,
                        input logic [OFS_W-1:0] ofs, input logic t);
    @(posedge core_clk);
    op <= o;
    dst_value <= d;
    src_value <= s;
    io_value <= s;
    imm_value <= k;
    bit_index <= b;
    offset <= ofs;
    next_two_word <= t;
    op_valid <= 1'b1;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    cyc = 1;
    while (op_ready !== 1'b1 && cyc < 8) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_alu();
    alu_case_t tc [24] = '{
      '{add_regs, 8'h0F, 8'h01, 8'h00, 8'h10, 8'h20, 1'b1}, '{add_with_carry, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h23, 1'b1},
      '{add_with_carry, 8'h7F, 8'h00, 8'h00, 8'h80, 8'h2C, 1'b1}, '{minus_regs, 8'h10, 8'h01, 8'h00, 8'h0F, 8'h20, 1'b1},
      '{minus_immediate, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h35, 1'b1},
      '{minus_imm_with_borrow, 8'h80, 8'h00, 8'h00, 8'h7F, 8'h38, 1'b1},
      '{minus_with_borrow, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 1'b1},
      '{compare_immediate, 8'h05, 8'h00, 8'h05, 8'h00, 8'h02, 1'b0},
      '{compare_regs, 8'h03, 8'h05, 8'h00, 8'hFE, 8'h35, 1'b0}, '{and_regs, 8'hF0, 8'h8F, 8'h00, 8'h80, 8'h35, 1'b1},
      '{exclusive_or_regs, 8'h55, 8'h55, 8'h00, 8'h00, 8'h23, 1'b1},
      '{merge_immediate_bits, 8'h01, 8'h00, 8'h80, 8'h81, 8'h35, 1'b1},
      '{mask_with_immediate, 8'hFF, 8'h00, 8'h0F, 8'h0F, 8'h21, 1'b1},
      '{clear_mask_bits, 8'hFF, 8'h00, 8'h0F, 8'hF0, 8'h35, 1'b1},
      '{zero_or_sign_check, 8'h00, 8'h00, 8'h00, 8'h00, 8'h23, 1'b1},
      '{all_ones_load, 8'h12, 8'h00, 8'h00, 8'hFF, 8'h23, 1'b1}, '{plus_one, 8'h7F, 8'h00, 8'h00, 8'h80, 8'h2D, 1'b1},
      '{minus_one, 8'h80, 8'h00, 8'h00, 8'h7F, 8'h39, 1'b1}, '{bitwise_invert, 8'h0F, 8'h00, 8'h00, 8'hF0, 8'h35, 1'b1},
      '{or_regs, 8'h0A, 8'h50, 8'h00, 8'h5A, 8'h21, 1'b1},
      '{set_mask_bits, 8'h40, 8'h00, 8'h03, 8'h43, 8'h21, 1'b1},
      '{zero_register, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h23, 1'b1},
      '{compare_with_borrow, 8'h06, 8'h05, 8'h00, 8'h00, 8'h02, 1'b0},
      '{sign_flip, 8'h80, 8'h00, 8'h00, 8'h80, 8'h0D, 1'b1}};
    foreach (tc[i]) begin
      run_op(tc[i].op, tc[i].d, tc[i].s, tc[i].k, 3'h0, 12'h000, 1'b0);
      exp_pc = exp_pc + 1'b1;
      chk_data("result_value", tc[i].r, result_value);
      chk_bit("result_we", tc[i].w, result_we);
      chk_data("cpu_flags_register", tc[i].f, cpu_flags_register);
      chk_pc("pc", exp_pc, pc);
      chk_data("cycles", 8'h01, 8'(cyc));
    end
    $display("test alu done");
  endtask

  // flags stand at 0D here: V, N and C set, the rest clear
  task automatic t_flow();
    flow_case_t tc [20] = '{
      '{relative_jump, 8'h00, 3'h0, 12'h005, 1'b0, 6, 2}, '{relative_jump, 8'h00, 3'h0, 12'hFFD, 1'b0, -2, 2},
      '{relative_subroutine_call, 8'h00, 3'h0, 12'h004, 1'b0, 5, 3}, '{equal_skip, 8'h33, 3'h0, 12'h000, 1'b0, 2, 2},
      '{equal_skip, 8'h33, 3'h0, 12'h000, 1'b1, 3, 2}, '{equal_skip, 8'h34, 3'h0, 12'h000, 1'b0, 1, 1},
      '{skip_if_reg_bit_clear, 8'hFB, 3'h2, 12'h000, 1'b0, 2, 2},
      '{skip_if_reg_bit_set, 8'hFB, 3'h2, 12'h000, 1'b0, 1, 1},
      '{skip_if_io_bit_set, 8'h80, 3'h7, 12'h000, 1'b1, 3, 2}, '{skip_if_io_bit_clear, 8'h80, 3'h7, 12'h000, 1'b0, 1, 1},
      '{branch_on_flag_set, 8'h00, 3'h0, 12'h007, 1'b0, 8, 2}, '{branch_unsigned_ge, 8'h00, 3'h0, 12'h002, 1'b0, 1, 1},
      '{branch_unsigned_lt, 8'h00, 3'h0, 12'h002, 1'b0, 3, 2}, '{branch_signed_lt, 8'h00, 3'h0, 12'h002, 1'b0, 1, 1},
      '{branch_signed_ge, 8'h00, 3'h0, 12'h001, 1'b0, 2, 2}, '{branch_on_flag_clear, 8'h00, 3'h5, 12'h000, 1'b0, 1, 2},
      '{branch_on_flag_set, 8'h00, 3'h6, 12'h003, 1'b0, 1, 1}, '{branch_on_flag_set, 8'h00, 3'h3, 12'hFFF, 1'b0, 0, 2},
      '{branch_on_flag_clear, 8'h00, 3'h1, 12'h001, 1'b0, 2, 2}, '{branch_on_flag_set, 8'h00, 3'h7, 12'h004, 1'b0, 1, 1}};
    foreach (tc[i]) begin
      run_op(tc[i].op, 8'h33, tc[i].s, 8'h00, tc[i].b, tc[i].o, tc[i].t);
      if (tc[i].op == relative_subroutine_call)
        chk_pc("push_pc", exp_pc + 1'b1, push_pc);
      exp_pc = exp_pc + tc[i].dp[PC_W-1:0];
      chk_pc("pc", exp_pc, pc);
      chk_data("cpu_flags_register", 8'h0D, cpu_flags_register);
      chk_data("cycles", 8'(tc[i].cy), 8'(cyc));
    end
    $display("test flow done");
  endtask

  task automatic t_return();
    @(posedge core_clk);
    stack_pc <= 9'h123;
    run_op(interrupt_exit, 8'h00, 8'h00, 8'h00, 3'h0, 12'h000, 1'b0);
    chk_pc("pc", 9'h123, pc);
    chk_data("cpu_flags_register", 8'h8D, cpu_flags_register);
    chk_data("cycles", 8'h04, 8'(cyc));
    @(posedge core_clk);
    stack_pc <= 9'h040;
    run_op(subroutine_exit, 8'h00, 8'h00, 8'h00, 3'h0, 12'h000, 1'b0);
    chk_pc("pc", 9'h040, pc);
    chk_data("cpu_flags_register", 8'h8D, cpu_flags_register);
    chk_data("cycles", 8'h04, 8'(cyc));
    run_op(branch_on_flag_set, 8'h00, 8'h00, 8'h00, 3'h7, 12'h002, 1'b0);
    chk_pc("pc", 9'h043, pc);
    chk_data("cycles", 8'h02, 8'(cyc));
    $display("test return done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    exp_pc = 9'h000;
    t_alu();
    t_flow();
    t_return();
    complete_run();
  end
endmodule
